/* dv/smbus_host_model.sv */
// Behavioural SMBus host for register transfers
`timescale 1ns/1ps
module smbus_host_model (
  // Bus pins; data is open drain, released reads high
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One pulse, 80 ns low and 80 ns high; data moves only while low
  task automatic put_bit(input logic b, output logic got);
    sda_drv = b;
    #40;
    scl = 1'b1;
    #40;
    got = sda_line;
    #40;
    scl = 1'b0;
    #40;
  endtask
  // Start, also usable as repeated start
  task automatic start_c;
    sda_drv = 1'b1;
    #40;
    scl = 1'b1;
    #80;
    sda_drv = 1'b0;
    #80;
    scl = 1'b0;
    #40;
  endtask
  task automatic stop_c;
    sda_drv = 1'b0;
    #40;
    scl = 1'b1;
    #80;
    sda_drv = 1'b1;
    #80;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], g);
    end
    put_bit(1'b1, nak);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      b[i] = g;
    end
    put_bit(last, g);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic n0, n1, n2;
    start_c;
    send_byte({a, 1'b0}, n0);
    send_byte(c, n1);
    send_byte(d, n2);
    stop_c;
    ok = !(n0 | n1 | n2);
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d, output logic ok);
    logic n0, n1, n2;
    start_c;
    send_byte({a, 1'b0}, n0);
    send_byte(c, n1);
    start_c;
    send_byte({a, 1'b1}, n2);
    get_byte(1'b1, d);
    stop_c;
    ok = !(n0 | n1 | n2);
  endtask
  // send byte moves the pointer only
  task automatic send_cmd(input logic [6:0] a, input logic [7:0] c, output logic ok);
    logic n0, n1;
    start_c;
    send_byte({a, 1'b0}, n0);
    send_byte(c, n1);
    stop_c;
    ok = !(n0 | n1);
  endtask
  // receive byte; sole master, pointer is ours
  task automatic recv(input logic [6:0] a, output logic [7:0] d, output logic ok);
    logic n0;
    start_c;
    send_byte({a, 1'b1}, n0);
    get_byte(1'b1, d);
    stop_c;
    ok = !n0;
  endtask
endmodule

/* dv/thermal_monitor_fan_pwm_props.sv */
// Pin-level assertion checker for the thermal monitor
`timescale 1ns/1ps
module thermal_monitor_fan_pwm_props
  import thermal_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Alarm and fans
  input wire logic overtemp_alarm_n,
  input wire logic pwm1,
  input wire logic pwm2
);
  logic in_frame;
  logic sda_q;
  logic [31:0] conv_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Frame and conversion phase; start and stop only count with the clock line high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_frame <= 1'b0;
      sda_q <= 1'b1;
      conv_cnt <= 32'h0;
    end else begin
      sda_q <= sda_in;
      if (scl && sda_q && !sda_in) begin
        in_frame <= 1'b1;
      end else if (scl && !sda_q && sda_in) begin
        in_frame <= 1'b0;
      end
      conv_cnt <= (conv_cnt == 32'(CONV_CYCLES - 1)) ? 32'h0 : conv_cnt + 32'h1;
    end
  end
  // Properties; pin sampling is asynchronous, so latencies carry a cycle of slack
  property p_reset_idle;
    $rose(nrst) |-> sda_oe_n && overtemp_alarm_n && !pwm1 && !pwm2;
  endproperty
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  property p_ack_timing;
    $fell(sda_oe_n) |-> !scl && $past(scl, 8);
  endproperty
  property p_release_low;
    $rose(sda_oe_n) |-> !scl;
  endproperty
  property p_drive_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  property p_idle_quiet;
    !in_frame |-> sda_oe_n;
  endproperty
  property p_alarm_release;
    $rose(overtemp_alarm_n) |-> !scl;
  endproperty
  property p_alarm_fall;
    $fell(overtemp_alarm_n) |-> conv_cnt <= 32'h4 || !scl;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  a_ack_timing: assert property (p_ack_timing) else $error("data drive outside clock low");
  a_release_low: assert property (p_release_low) else $error("data released with clock high");
  a_drive_hold: assert property (p_drive_hold) else $error("data bit too short");
  a_idle_quiet: assert property (p_idle_quiet) else $error("data driven outside frame");
  a_alarm_release: assert property (p_alarm_release) else $error("alarm released without bus");
  a_alarm_fall: assert property (p_alarm_fall) else $error("alarm set off conversion");
  c_alarm: cover property ($fell(overtemp_alarm_n));
  c_ack: cover property ($fell(sda_oe_n));
  c_fan: cover property ($rose(pwm2));
endmodule

/* dv/thermal_monitor_fan_pwm_test.sv */
// Self-checking bench for the thermal monitor and fan drive
`timescale 1ns/1ps
module thermal_monitor_fan_pwm_test
  import thermal_pkg::*;
;
  // Shortened counts keep the run brief; 35 kHz code gives 240 x 11 clocks
  localparam int CONV = 200;
  localparam int SPIN = 6000;
  localparam int STRAP = 50;
  localparam int PER = 2640;
  typedef struct packed {logic wr; logic [7:0] cmd; logic [7:0] wdata; logic [7:0] exp;} row_s;
  logic clk, nrst, scl, host_sda, sda_out, sda_oe_n, overtemp_alarm_n, pwm1, pwm2, ok;
  logic [1:0] address_strap_a, address_strap_b;
  logic signed [10:0] local_code;
  logic [7:0] thermistor_input1, thermistor_input2, got;
  logic [6:0] dev_addr;
  logic [15:0] n_high;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  wire logic sda_line = host_sda & (sda_oe_n | sda_out);
  row_s rows [8] = '{'{1'b0, 8'h02, 8'h00, 8'h10}, '{1'b0, 8'h13, 8'h00, 8'h6E}, '{1'b0, 8'h14, 8'h00, 8'h50},
    '{1'b0, 8'h12, 8'h00, 8'h00}, '{1'b1, 8'h0B, 8'hFF, 8'hF0}, '{1'b1, 8'h12, 8'h07, 8'h07},
    '{1'b1, 8'h20, 8'hAA, 8'h00}, '{1'b1, 8'h16, 8'h00, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////////
  thermal_monitor_fan_pwm #(.CONV_CYCLES(CONV), .SPIN_CYCLES(SPIN), .STRAP_CYCLES(STRAP)) i_thermal_monitor_fan_pwm (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_strap_a(address_strap_a), .address_strap_b(address_strap_b), .local_code(local_code),
    .thermistor_input1(thermistor_input1), .thermistor_input2(thermistor_input2),
    .overtemp_alarm_n(overtemp_alarm_n), .pwm1(pwm1), .pwm2(pwm2));
  smbus_host_model i_smbus_host_model (.scl(scl), .sda_drv(host_sda), .sda_line(sda_line));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      finish_test();
    end
  end
  // Helpers; inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    i_smbus_host_model.write_reg(dev_addr, cmd, data, ok);
    check("write ack", 16'h1, {15'h0, ok});
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    i_smbus_host_model.read_reg(dev_addr, cmd, got, ok);
    check("read ack", 16'h1, {15'h0, ok});
    check($sformatf("register %h", cmd), {8'h0, exp}, {8'h0, got});
  endtask
  // Window of one period makes the count independent of phase
  task automatic count_high(input logic fan2, input logic [15:0] exp);
    n_high = 16'h0;
    repeat (PER) begin
      @(posedge clk);
      #1;
      n_high = n_high + {15'h0, fan2 ? pwm2 : pwm1};
    end
    check("pwm high count", exp, n_high);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    address_strap_a = 2'h2;
    address_strap_b = 2'h1;
    local_code = 11'sh0;
    thermistor_input1 = 8'h20;
    thermistor_input2 = 8'h10;
    dev_addr = 7'h4D;
    tick(4);
    nrst = 1'b1;
    tick(1);
    check("idle outputs", 16'hC, {12'h0, sda_oe_n, overtemp_alarm_n, pwm1, pwm2});
    tick(STRAP + 10);
    i_smbus_host_model.read_reg(7'h18, REG_CONFIG, got, ok);
    check("foreign address ack", 16'h0, {15'h0, ok});
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].cmd, rows[i].wdata);
      end
      rd(rows[i].cmd, rows[i].exp);
    end
    wr(REG_CONFIG, 8'h30);
    wr(REG_OFFSET, 8'hF0);
    thermistor_input1 = 8'h40;
    local_code = 11'sd203;
    tick(2 * CONV + 10);
    rd(REG_TEMP1, 8'h30);
    rd(REG_TEMP2, 8'h19);
    rd(REG_FRAC, 8'h60);
    wr(REG_OFFSET, 8'h80);
    local_code = -11'sd8;
    tick(2 * CONV + 10);
    rd(REG_TEMP1, 8'h00);
    rd(REG_TEMP2, 8'h00);
    rd(REG_FRAC, 8'h00);
    i_smbus_host_model.send_cmd(dev_addr, REG_OT_LIM1, ok);
    i_smbus_host_model.recv(dev_addr, got, ok);
    check("receive after send", 16'h6E, {8'h0, got});
    rd(REG_OT_LIM2, 8'h50);
    i_smbus_host_model.recv(dev_addr, got, ok);
    check("receive after read", 16'h50, {8'h0, got});
    wr(REG_OFFSET, 8'h00);
    thermistor_input1 = 8'h70;
    tick(2 * CONV + 10);
    check("alarm set", 16'h0, {15'h0, overtemp_alarm_n});
    thermistor_input1 = 8'h20;
    tick(2 * CONV + 10);
    check("alarm latched", 16'h0, {15'h0, overtemp_alarm_n});
    rd(REG_OT_STATUS, 8'h01);
    tick(2);
    check("alarm cleared", 16'h1, {15'h0, overtemp_alarm_n});
    thermistor_input1 = 8'h70;
    tick(2 * CONV + 10);
    check("alarm again", 16'h0, {15'h0, overtemp_alarm_n});
    wr(REG_OT_MASK, 8'h01);
    tick(2);
    check("alarm masked", 16'h1, {15'h0, overtemp_alarm_n});
    tick(2 * CONV + 10);
    rd(REG_OT_STATUS, 8'h01);
    check("alarm stays masked", 16'h1, {15'h0, overtemp_alarm_n});
    wr(REG_DUTY1, 8'h00);
    tick(2 * PER);
    wr(REG_DUTY1, 8'h3C);
    tick(PER);
    count_high(1'b0, 16'd2640);
    tick(3 * PER);
    count_high(1'b0, 16'd660);
    wr(REG_CONFIG, 8'h20);
    tick(2 * PER);
    count_high(1'b0, 16'd1980);
    wr(REG_CONFIG, 8'h34);
    wr(REG_DUTY2, 8'h3C);
    tick(2 * PER);
    count_high(1'b1, 16'd660);
    // Automatic mode on channel 1: 112 C against a 90 C start gives duty 44
    wr(REG_FST1, 8'h5A);
    wr(REG_FAN_CFG, 8'h10);
    tick(2 * CONV + PER + 10);
    count_high(1'b0, 16'd484);
    address_strap_a = 2'h0;
    address_strap_b = 2'h0;
    dev_addr = 7'h18;
    tick(2 * STRAP + 10);
    rd(REG_CONFIG, 8'h34);
    finish_test();
  end
endmodule
bind thermal_monitor_fan_pwm thermal_monitor_fan_pwm_props #(.CONV_CYCLES(CONV_CYCLES)) i_thermal_monitor_fan_pwm_props (
  .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .overtemp_alarm_n(overtemp_alarm_n), .pwm1(pwm1), .pwm2(pwm2));

/* verilog/thermal_monitor_fan_pwm.sv */
// Two-channel thermal monitor with alarm, fan PWM outputs and SMBus slave register access
`timescale 1ns/1ps
module thermal_monitor_fan_pwm
  import thermal_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int SPIN_CYCLES = SPIN_CYC,
  parameter int STRAP_CYCLES = STRAP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // SMBus pins, open drain data
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps: 0 low, 1 floating, 2 high
  input wire logic [1:0] address_strap_a,
  input wire logic [1:0] address_strap_b,
  // Converter front end results
  input wire logic signed [10:0] local_code,
  input wire logic [7:0] thermistor_input1,
  input wire logic [7:0] thermistor_input2,
  // Alarm and fan outputs
  output logic overtemp_alarm_n,
  output logic pwm1,
  output logic pwm2
);
  typedef struct packed {
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [1:0] sa_m, sa_s, sb_m, sb_s;
    logic [6:0] slave_addr;
    logic [23:0] strap_cnt;
    bus_e bus;
    bus_e after_ack;
    logic [3:0] bits;
    logic [7:0] shreg, tx, pointer;
    logic sda_oe_n;
    logic [7:0] temp1, temp2, frac, config_byte, duty1, duty2, offset, fan_cfg, freq;
    logic [7:0] fst1, fst2, ot_lim1, ot_lim2;
    logic [1:0] ot_status, ot_mask;
    logic [27:0] conv_cnt;
    logic conv_ch;
    fan_s [1:0] fan;
    logic alarm_n;
  } state_s;
  state_s st, next_st;
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Register read mux; unmapped reads as zero
  function automatic logic [7:0] reg_read(input state_s s, input logic [7:0] a);
    case (a)
      REG_TEMP1: reg_read = s.temp1;
      REG_TEMP2: reg_read = s.temp2;
      REG_CONFIG: reg_read = s.config_byte;
      REG_DUTY1: reg_read = s.duty1;
      REG_DUTY2: reg_read = s.duty2;
      REG_FST1: reg_read = s.fst1;
      REG_FST2: reg_read = s.fst2;
      REG_FAN_CFG: reg_read = s.fan_cfg;
      REG_FREQ: reg_read = s.freq;
      REG_OT_LIM1: reg_read = s.ot_lim1;
      REG_OT_LIM2: reg_read = s.ot_lim2;
      REG_OT_STATUS: reg_read = {6'h00, s.ot_status};
      REG_OT_MASK: reg_read = {6'h00, s.ot_mask};
      REG_OFFSET: reg_read = s.offset;
      REG_FRAC: reg_read = s.frac;
      default: reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic rise, fall, start_c, stop_c, read_clear, conv_end;
    logic [7:0] t, fst, sel, auto_duty;
    logic [1:0] over;
    int div;
    next_st = st;
    rise = 1'b0;
    fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    read_clear = 1'b0;
    conv_end = 1'b0;
    t = 8'h00;
    fst = 8'h00;
    sel = 8'h00;
    auto_duty = 8'h00;
    over = 2'h0;
    div = 1;
    // Pin synchronisers; second stages and the scl/sda third stages feed logic
    next_st.scl_m = scl;
    next_st.scl_s = st.scl_m;
    next_st.scl_d = st.scl_s;
    next_st.sda_m = sda_in;
    next_st.sda_s = st.sda_m;
    next_st.sda_d = st.sda_s;
    next_st.sa_m = address_strap_a;
    next_st.sa_s = st.sa_m;
    next_st.sb_m = address_strap_b;
    next_st.sb_s = st.sb_m;
    rise = st.scl_s & ~st.scl_d;
    fall = ~st.scl_s & st.scl_d;
    start_c = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
    stop_c = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;
    // straps rechecked periodically, only while bus is idle
    if (st.strap_cnt >= 24'(STRAP_CYCLES - 1)) begin
      if (st.bus == IDLE) begin
        next_st.strap_cnt = 24'h000000;
        next_st.slave_addr = strap_addr(st.sa_s, st.sb_s);
      end
    end else begin
      next_st.strap_cnt = st.strap_cnt + 24'h000001;
    end
    if (start_c) begin
      next_st.bus = ADDR;
      next_st.bits = 4'h0;
      next_st.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      next_st.bus = IDLE;
      next_st.sda_oe_n = 1'b1;
    end else begin
      unique case (st.bus)
        IDLE: ;
        ADDR, CMD, WDATA: begin
          if (rise && st.bits != 4'h8) begin
            next_st.shreg = {st.shreg[6:0], st.sda_s};
            next_st.bits = st.bits + 4'h1;
          end else if (fall && st.bits == 4'h8) begin
            next_st.bits = 4'h0;
            next_st.bus = ACK;
            next_st.sda_oe_n = 1'b0;
            if (st.bus == ADDR) begin
              if (st.shreg[7:1] != st.slave_addr) begin
                next_st.bus = IDLE;
                next_st.sda_oe_n = 1'b1;
              end else if (st.shreg[0]) begin
                // read and receive byte use the stored pointer
                next_st.after_ack = RDATA;
                next_st.tx = reg_read(st, st.pointer);
                read_clear = (st.pointer == REG_OT_STATUS);
              end else begin
                next_st.after_ack = CMD;
              end
            end else if (st.bus == CMD) begin
              // Send byte ends here; write byte continues to data
              next_st.pointer = st.shreg;
              next_st.after_ack = WDATA;
            end else begin
              next_st.after_ack = WDATA;
              case (st.pointer)
                REG_CONFIG: next_st.config_byte = st.shreg;
                REG_DUTY1: next_st.duty1 = (st.shreg > DUTY_MAX) ? DUTY_MAX : st.shreg;
                REG_DUTY2: next_st.duty2 = (st.shreg > DUTY_MAX) ? DUTY_MAX : st.shreg;
                REG_FST1: next_st.fst1 = st.shreg;
                REG_FST2: next_st.fst2 = st.shreg;
                REG_FAN_CFG: next_st.fan_cfg = st.shreg;
                REG_FREQ: next_st.freq = st.shreg;
                REG_OT_LIM1: next_st.ot_lim1 = st.shreg;
                REG_OT_LIM2: next_st.ot_lim2 = st.shreg;
                REG_OT_MASK: next_st.ot_mask = st.shreg[1:0];
                REG_OFFSET: next_st.offset = st.shreg;
                default: ;
              endcase
            end
          end
        end
        ACK: begin
          if (fall) begin
            next_st.bus = st.after_ack;
            next_st.sda_oe_n = (st.after_ack == RDATA) ? st.tx[7] : 1'b1;
          end
        end
        RDATA: begin
          if (rise) begin
            next_st.bits = st.bits + 4'h1;
          end else if (fall) begin
            if (st.bits == 4'h8) begin
              next_st.bus = MACK;
              next_st.sda_oe_n = 1'b1;
            end else begin
              next_st.sda_oe_n = st.tx[3'(4'h7 - st.bits)];
            end
          end
        end
        MACK: begin
          // Master nack ends the read; ack repeats the same register
          if (rise && st.sda_s) begin
            next_st.bus = IDLE;
          end else if (rise) begin
            next_st.bits = 4'h0;
            next_st.after_ack = RDATA;
            next_st.bus = ACK;
          end
        end
      endcase
    end
    // alternate channels, one integration period each
    if (st.conv_cnt >= 28'(CONV_CYCLES - 1)) begin
      next_st.conv_cnt = 28'h0000000;
      next_st.conv_ch = ~st.conv_ch;
      conv_end = 1'b1;
    end else begin
      next_st.conv_cnt = st.conv_cnt + 28'h0000001;
    end
    if (conv_end) begin
      if (!st.conv_ch) begin
        // thermistor ratio plus offset, clipped at zero
        next_st.temp1 = clip_sum(thermistor_input1, st.offset);
        over[0] = (next_st.temp1 > st.ot_lim1);
      end else begin
        if (st.config_byte[CFG_LOCAL2]) begin
          // local integer and three-bit fraction, negatives read zero
          next_st.temp2 = local_code[10] ? 8'h00 : {1'b0, local_code[9:3]};
          next_st.frac = local_code[10] ? 8'h00 : {local_code[2:0], 5'h00};
        end else begin
          next_st.temp2 = clip_sum(thermistor_input2, st.offset);
        end
        over[1] = (next_st.temp2 > st.ot_lim2);
      end
    end
    // status sets on every over-limit conversion; set beats read clear
    next_st.ot_status = (read_clear ? 2'h0 : st.ot_status) | over;
    // only unmasked flags drive the alarm
    next_st.alarm_n = ~|(next_st.ot_status & ~next_st.ot_mask);
    // Fans
    for (int f = 0; f < 2; f++) begin
      sel = (f == 0) ? {6'h00, st.fan_cfg[5:4]} : {6'h00, st.fan_cfg[3:2]};
      t = (sel == 8'h01) ? next_st.temp1 : next_st.temp2;
      fst = (sel == 8'h01) ? st.fst1 : st.fst2;
      auto_duty = (t > fst) ? 8'((t - fst) * DUTY_STEP) : 8'h00;
      if (auto_duty > DUTY_MAX || (t > fst && t - fst > DUTY_MAX)) begin
        auto_duty = DUTY_MAX;
      end
      if (sel == 8'h00) begin
        // manual mode target follows the duty register
        next_st.fan[f].target = (f == 0) ? st.duty1 : st.duty2;
      end else if (conv_end && (st.conv_ch == (sel != 8'h01))) begin
        // recalc on new peak or a 5 degree fall from it
        if (t > st.fan[f].peak || 9'(t) + 9'(PEAK_DROP) <= 9'(st.fan[f].peak)) begin
          next_st.fan[f].peak = t;
          next_st.fan[f].target = {auto_duty[7:1], 1'b0};
        end
      end
      // standstill start gets full drive first
      if (st.fan[f].spin != 28'h0) begin
        next_st.fan[f].spin = st.fan[f].spin - 28'h1;
      end else if (st.fan[f].duty_l == 8'h00 && !st.fan[f].spin_l && next_st.fan[f].target != 8'h00 &&
                   !st.config_byte[CFG_SPIN_OFF]) begin
        next_st.fan[f].spin = 28'(SPIN_CYCLES);
      end
      div = int'(CLK_HZ / (PWM_STEPS * pwm_hz(st.freq[2:0])));
      if (st.fan[f].pre >= 14'(div - 1)) begin
        next_st.fan[f].pre = 14'h0000;
        if (st.fan[f].cnt == 8'(PWM_STEPS - 1)) begin
          next_st.fan[f].cnt = 8'h00;
          // duty and spin latch only at period start
          // with spin-up off the target applies directly, no ramp
          next_st.fan[f].duty_l = next_st.fan[f].target;
          next_st.fan[f].spin_l = (next_st.fan[f].spin != 28'h0);
        end else begin
          next_st.fan[f].cnt = st.fan[f].cnt + 8'h01;
        end
      end else begin
        next_st.fan[f].pre = st.fan[f].pre + 14'h0001;
      end
      // polarity, invert bit one gives active-high pulse
      next_st.fan[f].pwm = ~((st.fan[f].spin_l | (st.fan[f].cnt < st.fan[f].duty_l))
                             ^ st.config_byte[CFG_INVERT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.scl_m <= 1'b1;
      st.scl_s <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_m <= 1'b1;
      st.sda_s <= 1'b1;
      st.sda_d <= 1'b1;
      st.slave_addr <= ADDR_RST;
      st.bus <= IDLE;
      st.after_ack <= IDLE;
      st.sda_oe_n <= 1'b1;
      st.config_byte <= CONFIG_RST;
      st.freq <= FREQ_RST;
      st.ot_lim1 <= OT_LIM1_RST;
      st.ot_lim2 <= OT_LIM2_RST;
      st.alarm_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // Outputs straight from state flops; data pin only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = st.sda_oe_n;
  assign overtemp_alarm_n = st.alarm_n;
  assign pwm1 = st.fan[0].pwm;
  assign pwm2 = st.fan[1].pwm;
endmodule

/* verilog/thermal_pkg.sv */
// Package: register map, reset values, timing constants and state types of the thermal monitor
package thermal_pkg;
  // Clock and timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint CONV_MS = 120;
  localparam int CONV_CYC = int'(CLK_HZ * CONV_MS / 1000);
  localparam longint SPIN_S = 2;
  localparam int SPIN_CYC = int'(CLK_HZ * SPIN_S);
  localparam longint STRAP_US = 1000;
  localparam int STRAP_CYC = int'(CLK_HZ * STRAP_US / 1_000_000);
  localparam int PWM_STEPS = 240;
  localparam logic [7:0] DUTY_MAX = 8'hF0;
  localparam logic [7:0] DUTY_STEP = 8'h02;
  localparam logic [7:0] PEAK_DROP = 8'h05;
  // Register offsets
  localparam logic [7:0] REG_TEMP1 = 8'h00;
  localparam logic [7:0] REG_TEMP2 = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h02;
  localparam logic [7:0] REG_DUTY1 = 8'h0B;
  localparam logic [7:0] REG_DUTY2 = 8'h0C;
  localparam logic [7:0] REG_FST1 = 8'h0F;
  localparam logic [7:0] REG_FST2 = 8'h10;
  localparam logic [7:0] REG_FAN_CFG = 8'h11;
  localparam logic [7:0] REG_FREQ = 8'h12;
  localparam logic [7:0] REG_OT_LIM1 = 8'h13;
  localparam logic [7:0] REG_OT_LIM2 = 8'h14;
  localparam logic [7:0] REG_OT_STATUS = 8'h15;
  localparam logic [7:0] REG_OT_MASK = 8'h16;
  localparam logic [7:0] REG_OFFSET = 8'h17;
  localparam logic [7:0] REG_FRAC = 8'h1E;
  // Configuration bit positions
  localparam int CFG_SPIN_OFF = 2;
  localparam int CFG_INVERT = 4;
  localparam int CFG_LOCAL2 = 5;
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] OT_LIM1_RST = 8'h6E;
  localparam logic [7:0] OT_LIM2_RST = 8'h50;
  localparam logic [7:0] FREQ_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h18;
  // Strap levels
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;

  typedef enum logic [2:0] {IDLE, ADDR, CMD, WDATA, ACK, RDATA, MACK} bus_e;

  typedef struct packed {
    logic [7:0] peak;
    logic [7:0] target;
    logic [27:0] spin;
    logic [7:0] duty_l;
    logic spin_l;
    logic [13:0] pre;
    logic [7:0] cnt;
    logic pwm;
  } fan_s;

  // PWM output frequency for each select code; 33 Hz lowest, 35 kHz top
  function automatic int pwm_hz(input logic [2:0] sel);
    case (sel)
      3'h0: pwm_hz = 33;
      3'h1: pwm_hz = 66;
      3'h2: pwm_hz = 132;
      3'h3: pwm_hz = 264;
      3'h4: pwm_hz = 528;
      3'h5: pwm_hz = 1056;
      3'h6: pwm_hz = 2112;
      default: pwm_hz = 35000;
    endcase
  endfunction

  // Strap pair to slave address; first strap picks the group, second adds to the low bits
  function automatic logic [6:0] strap_addr(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] hi;
    logic [2:0] lo;
    hi = (a == STRAP_LOW) ? 4'h3 : (a == STRAP_FLOAT) ? 4'h5 : 4'h9;
    lo = (a == STRAP_LOW) ? 3'h0 : (a == STRAP_FLOAT) ? 3'h1 : 3'h4;
    lo = lo + ((b == STRAP_LOW) ? 3'h0 : (b == STRAP_FLOAT) ? 3'h1 : 3'h2);
    strap_addr = {hi, lo};
  endfunction

  // Thermistor code plus signed offset, clipped to 0..255
  function automatic logic [7:0] clip_sum(input logic [7:0] code, input logic [7:0] off);
    logic signed [9:0] sum;
    sum = $signed({2'h0, code}) + $signed({{2{off[7]}}, off});
    if (sum < 0) begin
      clip_sum = 8'h00;
    end else if (sum > 10'sd255) begin
      clip_sum = 8'hFF;
    end else begin
      clip_sum = sum[7:0];
    end
  endfunction
endpackage
